// ---- rtcam_pkg.sv ----
// Operation
// RULE1 - Month register holds BCD month 01..12 in bits 4:0; bits 7:5 ignored.
// RULE2 - Year register holds two BCD digits 00..99 across all eight bits.
// RULE3 - Host reads all time registers in one burst to avoid tearing.
// RULE4 - Each valid field with its disable bit clear is compared against current time.
// RULE5 - Minute alarm: bit 7 disables, bits 6:0 hold BCD minute 00..59.
// RULE6 - Hour alarm: bit 7 disables; 12h uses PM bit 5 plus 01..12, 24h 00..23.
// RULE7 - Day alarm: bit 7 disables, bits 5:0 hold BCD day 01..31.
// RULE8 - Weekday alarm: bit 7 disables, bits 2:0 hold weekday 0..6.
// RULE9 - Alarm flag sets when all enabled comparisons first match together.
// RULE10 - Alarm flag stays set until software clears it.
// RULE11 - After clearing, flag sets again only on a new match, not a persisting one.
// RULE12 - Fields with disable bit set are excluded from the match.
// RULE13 - Flag register write ANDs each flag with written bit.
// RULE14 - Flag register: tick flag bit 5, alarm flag bit 3, countdown flag bit 2.
// RULE15 - To clear only alarm flag, host writes 0 at bit 3, 1 at 5 and 2.
// RULE16 - Rewriting non-flag bits of flag register never changes behaviour.
// RULE17 - Hour-format bit selects 12h or 24h interpretation of hour fields.
// RULE18 - Alarm compare runs after every counter update so new matches are caught at once.
package rtcam_pkg;
  // ---------------------------------------------------------------
  // Register indices, byte address is 64 times the page plus four times the index
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL1 = 4'h0;
  localparam logic [3:0] IDX_FLAGS = 4'h1;
  localparam logic [3:0] IDX_MONTH = 4'h7;
  localparam logic [3:0] IDX_YEAR = 4'h8;
  localparam logic [3:0] IDX_AMIN = 4'h9;
  localparam logic [3:0] IDX_AHOUR = 4'hA;
  localparam logic [3:0] IDX_ADAY = 4'hB;
  localparam logic [3:0] IDX_AWDAY = 4'hC;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h1;
  localparam logic [3:0] IDX_IRQ_EN = 4'h2;
  localparam logic [3:0] IDX_IRQ_CLR = 4'h3;
  localparam logic [1:0] PAGE_RTC = 2'h0;
  localparam logic [1:0] PAGE_IRQ = 2'h1;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_DIS = 7;
  localparam int BIT_PM = 5;
  localparam int BIT_TICKF = 5;
  localparam int BIT_ALRMF = 3;
  localparam int BIT_CNTF = 2;
  localparam int BIT_H12 = 2;
  localparam logic [7:0] FLAG_MASK = 8'h2C;
  localparam logic [7:0] MONTH_MASK = 8'h1F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] HOUR12_MASK = 8'h1F;
  localparam logic [7:0] DAY_MASK = 8'h3F;
  localparam logic [7:0] MIN_MASK = 8'h7F;
  localparam logic [7:0] WDAY_MASK = 8'h07;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ALARM = 8'h80;
  localparam logic [7:0] RST_MONTH = 8'h01;
  // ---------------------------------------------------------------
  // Timing and interrupt bits
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TICK_HZ = 1;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam logic [2:0] IRQ_ALARM = 3'h1;
  localparam logic [2:0] IRQ_TICK = 3'h2;
  localparam logic [2:0] IRQ_CNT = 3'h4;
endpackage

// ---- rtcam_tick.sv ----
`timescale 1ns/1ps
module rtcam_tick #(
  parameter int unsigned DIV = 25000000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [24:0] cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 25'h0000000;
      tick <= 1'b0;
    end else if (cnt_reg == 25'(DIV - 1)) begin
      cnt_reg <= 25'h0000000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 25'h0000001;
      tick <= 1'b0;
    end
  end
endmodule

// ---- rtcam_match.sv ----
`timescale 1ns/1ps
module rtcam_match (
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  input wire logic [7:0] alarm_day,
  input wire logic [7:0] alarm_wday,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_day,
  input wire logic [2:0] cur_wday,
  input wire logic hour12,
  output logic all_match
);
  logic [7:0] hmask;
  logic m_ok;
  logic h_ok;
  logic d_ok;
  logic w_ok;
  logic any_en;
  // ---------------------------------------------------------------
  // Field compares
  // ---------------------------------------------------------------
  // PM bit sits inside the 12h compare mask
  assign hmask = hour12 ? (rtcam_pkg::HOUR12_MASK | 8'h20) : rtcam_pkg::HOUR_MASK; // RULE17 RULE6
  assign m_ok = alarm_min[rtcam_pkg::BIT_DIS] ||
                ((alarm_min & rtcam_pkg::MIN_MASK) == (cur_min & rtcam_pkg::MIN_MASK)); // RULE5 RULE12
  assign h_ok = alarm_hour[rtcam_pkg::BIT_DIS] ||
                ((alarm_hour & hmask) == (cur_hour & hmask)); // RULE6 RULE12
  assign d_ok = alarm_day[rtcam_pkg::BIT_DIS] ||
                ((alarm_day & rtcam_pkg::DAY_MASK) == (cur_day & rtcam_pkg::DAY_MASK)); // RULE7
  assign w_ok = alarm_wday[rtcam_pkg::BIT_DIS] ||
                (alarm_wday[2:0] == cur_wday); // RULE8 RULE12
  // All fields disabled means no alarm at all
  assign any_en = !(alarm_min[7] && alarm_hour[7] && alarm_day[7] && alarm_wday[7]);
  assign all_match = any_en && m_ok && h_ok && d_ok && w_ok; // RULE4
endmodule

// ---- rtcam_top.sv ----
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module rtcam_top #(
  parameter int unsigned TICK_DIV = rtcam_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_day,
  input wire logic [2:0] cur_wday,
  input wire logic time_update,
  input wire logic tick_event,
  input wire logic countdown_event,
  output logic time_tick,
  output logic irq
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [1:0] page;
  logic [3:0] idx;
  logic wr_ok;
  logic ack_reg;
  assign page = avs_address[5:4];
  assign idx = avs_address[3:0];
  // Writes land at the edge where the master sees waitrequest low
  assign wr_ok = avs_write && ack_reg && avs_byteenable[0];

  // One wait state: every access answers on the second edge
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  function automatic logic hit(input logic [1:0] p, input logic [3:0] i,
                               input logic [1:0] wp, input logic [3:0] wi);
    hit = (p == wp) && (i == wi);
  endfunction

  // ---------------------------------------------------------------
  // Calendar and alarm registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl1_reg;
  logic [7:0] month_reg;
  logic [7:0] year_reg;
  logic [7:0] amin_reg;
  logic [7:0] ahour_reg;
  logic [7:0] aday_reg;
  logic [7:0] awday_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] wd;
  assign wd = avs_writedata[7:0];

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl1_reg <= rtcam_pkg::RST_ZERO;
      month_reg <= rtcam_pkg::RST_MONTH;
      year_reg <= rtcam_pkg::RST_ZERO;
      amin_reg <= rtcam_pkg::RST_ALARM;
      ahour_reg <= rtcam_pkg::RST_ALARM;
      aday_reg <= rtcam_pkg::RST_ALARM;
      awday_reg <= rtcam_pkg::RST_ALARM;
    end else if (wr_ok) begin
      if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_CTRL1)) begin
        ctrl1_reg <= wd;
      end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_MONTH)) begin
        month_reg <= wd & rtcam_pkg::MONTH_MASK; // RULE1
      end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_YEAR)) begin
        year_reg <= wd; // RULE2
      end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AMIN)) begin
        amin_reg <= wd; // RULE5
      end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AHOUR)) begin
        ahour_reg <= wd & 8'hBF; // RULE6
      end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_ADAY)) begin
        aday_reg <= wd & 8'hBF; // RULE7
      end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AWDAY)) begin
        awday_reg <= wd & 8'h87; // RULE8
      end
    end
  end

  // ---------------------------------------------------------------
  // Alarm detection
  // ---------------------------------------------------------------
  logic match_now;
  logic match_prev_reg;
  logic alarm_rise;

  rtcam_match u_match (
    .alarm_min(amin_reg),
    .alarm_hour(ahour_reg),
    .alarm_day(aday_reg),
    .alarm_wday(awday_reg),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_day(cur_day),
    .cur_wday(cur_wday),
    .hour12(ctrl1_reg[rtcam_pkg::BIT_H12]),
    .all_match(match_now)
  );

  // Sampled only on counter updates, so editing alarm registers alone never fires
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      match_prev_reg <= 1'b0;
    end else if (time_update) begin
      match_prev_reg <= match_now; // RULE18
    end
  end
  assign alarm_rise = time_update && match_now && !match_prev_reg; // RULE9 RULE11

  // ---------------------------------------------------------------
  // Flag register: AND on write, event set wins
  // ---------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    if (wr_ok && hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_FLAGS)) begin
      flags_next = flags_reg & (wd | ~rtcam_pkg::FLAG_MASK); // RULE13 RULE16
    end
    if (alarm_rise) begin
      flags_next[rtcam_pkg::BIT_ALRMF] = 1'b1; // RULE14 RULE10
    end
    if (tick_event) begin
      flags_next[rtcam_pkg::BIT_TICKF] = 1'b1;
    end
    if (countdown_event) begin
      flags_next[rtcam_pkg::BIT_CNTF] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      flags_reg <= rtcam_pkg::RST_ZERO;
    end else begin
      flags_reg <= flags_next & rtcam_pkg::FLAG_MASK; // RULE14
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, enable, clear
  // ---------------------------------------------------------------
  logic [2:0] ist_reg;
  logic [2:0] ien_reg;
  logic [2:0] iev;
  assign iev = {countdown_event, tick_event, alarm_rise};

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ist_reg <= 3'h0;
    end else begin
      // Set wins over clear
      if (wr_ok && hit(page, idx, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_CLR)) begin
        ist_reg <= (ist_reg & ~wd[2:0]) | iev;
      end else begin
        ist_reg <= ist_reg | iev;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ien_reg <= 3'h0;
    end else if (wr_ok && hit(page, idx, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_EN)) begin
      ien_reg <= wd[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_reg & ien_reg);
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_CTRL1)) begin
      rd = ctrl1_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_FLAGS)) begin
      rd = flags_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_MONTH)) begin
      rd = month_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_YEAR)) begin
      rd = year_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AMIN)) begin
      rd = amin_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AHOUR)) begin
      rd = ahour_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_ADAY)) begin
      rd = aday_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AWDAY)) begin
      rd = awday_reg;
    end else if (hit(page, idx, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_STAT)) begin
      rd = {5'h00, ist_reg};
    end else if (hit(page, idx, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_EN)) begin
      rd = {5'h00, ien_reg};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      if (avs_read && !ack_reg) begin
        avs_readdata <= {24'h000000, rd};
      end
    end
  end

  // ---------------------------------------------------------------
  // 1 Hz time chain
  // ---------------------------------------------------------------
  rtcam_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(ref_clk),
    .rst_n(rst_n_reg),
    .tick(time_tick)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_reg);

  // Decodes shared by the checks below
  logic flags_wr;
  logic af_clr;
  logic year_wr;
  logic irq_clr_wr;
  logic en_wr;
  logic all_off;
  assign flags_wr = wr_ok && hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_FLAGS);
  assign af_clr = flags_wr && !wd[rtcam_pkg::BIT_ALRMF];
  assign year_wr = wr_ok && hit(page, idx, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_YEAR);
  assign irq_clr_wr = wr_ok && hit(page, idx, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_CLR);
  assign en_wr = wr_ok && hit(page, idx, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_EN);
  assign all_off = amin_reg[7] && ahour_reg[7] && aday_reg[7] && awday_reg[7];

  // ---------------------------------------------------------------
  // Calendar and alarm flag checks
  // ---------------------------------------------------------------
  AST_ALARM_SET: assert property (alarm_rise |=> flags_reg[3]) // RULE9
    else $error("alarm flag not set on new match");
  AST_ALARM_HOLD: assert property (flags_reg[3] && !af_clr |=> flags_reg[3]) // RULE10
    else $error("alarm flag dropped without software clear");
  AST_NO_REFIRE: assert property (!time_update |=> !$rose(flags_reg[3])) // RULE11
    else $error("alarm flag set without time update");
  AST_AND_CLEAR: assert property (af_clr && !alarm_rise |=> !flags_reg[3]) // RULE13
    else $error("alarm flag not cleared by zero write");
  // Rewriting ones any number of times leaves the flags alone
  AST_FLAG_KEEP: assert property (flags_wr && wd[3] && !alarm_rise // RULE13 RULE16
    |=> flags_reg[3] == $past(flags_reg[3]))
    else $error("writing one changed the alarm flag");
  AST_FLAG_LAYOUT: assert property ((flags_reg & 8'hD3) == 8'h00) // RULE14 RULE16
    else $error("non-flag bits of flag register changed");
  AST_TICK_FLAG: assert property (tick_event |=> flags_reg[5]) // RULE14
    else $error("tick flag not set");
  AST_CNT_FLAG: assert property (countdown_event |=> flags_reg[2]) // RULE14
    else $error("countdown flag not set");
  // A match that persists across updates must stay quiet
  AST_PERSIST: assert property (match_prev_reg && !flags_reg[3] |=> !flags_reg[3]) // RULE11
    else $error("persisting match set the alarm flag again");
  AST_SAMPLE: assert property (time_update |=> match_prev_reg == $past(match_now)) // RULE18
    else $error("match not sampled on counter update");
  AST_MONTH_MASK: assert property (month_reg[7:5] == 3'h0) // RULE1
    else $error("month upper bits stored");
  AST_HOUR_BITS: assert property (!ahour_reg[6] && !aday_reg[6]) // RULE6 RULE7
    else $error("unused alarm bit stored");
  AST_WDAY_BITS: assert property (awday_reg[6:3] == 4'h0) // RULE8
    else $error("unused weekday alarm bits stored");
  AST_DISABLED: assert property (all_off |-> !alarm_rise) // RULE12 RULE4
    else $error("alarm fired with all fields disabled");
  AST_YEAR_WRITE: assert property (year_wr |=> year_reg == $past(wd)) // RULE2
    else $error("year write lost");

  // ---------------------------------------------------------------
  // Bus, interrupt and tick checks
  // ---------------------------------------------------------------
  // Exactly one wait state, so a master never sees a long stall
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && !ack_reg |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RD_UPPER: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  // Low byte lane off means the write is dropped but still answered
  AST_BE_IGNORED: assert property (avs_write && !avs_byteenable[0] |=> $stable(year_reg))
    else $error("write without low byte lane landed");
  AST_EN_WRITE: assert property (en_wr |=> ien_reg == $past(wd[2:0]))
    else $error("interrupt enable write lost");
  AST_IRQ: assert property (|(ist_reg & ien_reg) |=> irq)
    else $error("interrupt not raised");
  AST_IRQ_LOW: assert property (!(|(ist_reg & ien_reg)) |=> !irq)
    else $error("interrupt raised without enabled status");
  // Set wins over a clear landing in the same cycle
  AST_STAT_SET: assert property (iev[0] && irq_clr_wr |=> ist_reg[0])
    else $error("alarm status lost to a clear");
  AST_STAT_CLR: assert property (irq_clr_wr && wd[0] && !iev[0] |=> !ist_reg[0])
    else $error("alarm status not cleared");
  // Divider of at least two, so each tick is a single pulse
  AST_TICK_GAP: assert property (time_tick |=> !time_tick)
    else $error("tick longer than one cycle");

  COV_ALARM: cover property (alarm_rise);
  COV_CLEAR: cover property (flags_reg[3] ##1 !flags_reg[3]);
  COV_IRQ: cover property ($rose(irq));
  COV_REPEAT_CLR: cover property (af_clr ##1 alarm_rise);
  COV_TWELVE: cover property (alarm_rise && ctrl1_reg[rtcam_pkg::BIT_H12]);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic ref_clk;
  logic arst_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] cur_min, cur_hour, cur_day;
  logic [2:0] cur_wday;
  logic time_update, tick_event, countdown_event, time_tick, irq;
  int err_count, n_checks, cnt;
  logic [7:0] al [4];
  logic [7:0] rd, v, cm, ch, cd;
  logic [3:0] be_sel;
  logic pm, e_af, e_tf, e_cf;
  logic [2:0] e_st, e_en, cw;
  logic [3:0] ridx [8] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h1, 4'h0};
  logic [7:0] rmsk [8] = '{8'h1F, 8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'h87, 8'h2C, 8'h04};
  logic [7:0] rexp [8] = '{8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};

  // TICK_DIV shortened so the 1 Hz strobe shows within a short run
  rtcam_top #(.TICK_DIV(10)) rtcam_top_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cur_min(cur_min),
    .cur_hour(cur_hour), .cur_day(cur_day), .cur_wday(cur_wday), .time_update(time_update),
    .tick_event(tick_event), .countdown_event(countdown_event), .time_tick(time_tick),
    .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [1:0] pg, input logic [3:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge ref_clk);
    avs_address <= {pg, idx};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be_sel;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_count++;
      $display("BAD %0t bus timeout", $time);
      test_done();
    end else begin
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  function automatic logic hit_f(input logic [7:0] m, input logic [7:0] h,
                                 input logic [7:0] d, input logic [2:0] w);
    logic any;
    logic ok;
    any = 1'b0;
    ok = 1'b1;
    if (!al[0][7]) begin
      any = 1'b1;
      ok &= (al[0][6:0] == m[6:0]);
    end
    if (!al[1][7]) begin
      any = 1'b1;
      ok &= (al[1][5:0] == h[5:0]);
    end
    if (!al[2][7]) begin
      any = 1'b1;
      ok &= (al[2][5:0] == d[5:0]);
    end
    if (!al[3][7]) begin
      any = 1'b1;
      ok &= (al[3][2:0] == w);
    end
    return any && ok;
  endfunction

  function automatic logic [7:0] bcd(input int x);
    return 8'((x / 10) * 16 + x % 10);
  endfunction

  // Alarm fires only on a rising match seen at a counter update
  task automatic upd(input logic [7:0] m, input logic [7:0] h, input logic [7:0] d,
                     input logic [2:0] w);
    logic hit;
    @(posedge ref_clk);
    cur_min <= m;
    cur_hour <= h;
    cur_day <= d;
    cur_wday <= w;
    time_update <= 1'b1;
    @(posedge ref_clk);
    time_update <= 1'b0;
    hit = hit_f(m, h, d, w);
    if (hit && !pm) e_af = 1'b1;
    if (hit && !pm) e_st[0] = 1'b1;
    pm = hit;
  endtask

  task automatic evt(input logic t, input logic c);
    @(posedge ref_clk);
    tick_event <= t;
    countdown_event <= c;
    @(posedge ref_clk);
    tick_event <= 1'b0;
    countdown_event <= 1'b0;
    e_tf |= t;
    e_cf |= c;
    e_st |= {c, t, 1'b0};
  endtask

  task automatic wflags(input logic [7:0] d);
    bus(1'b1, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_FLAGS, d);
    e_tf &= d[5];
    e_af &= d[3];
    e_cf &= d[2];
  endtask

  task automatic walarm(input int i, input logic [7:0] d);
    bus(1'b1, rtcam_pkg::PAGE_RTC, 4'(rtcam_pkg::IDX_AMIN + i), d);
    al[i] = d;
  endtask

  task automatic wirq(input logic [3:0] idx, input logic [2:0] d);
    bus(1'b1, rtcam_pkg::PAGE_IRQ, idx, {5'h0, d});
    if (idx == rtcam_pkg::IDX_IRQ_EN) e_en = d;
    else e_st &= ~d;
  endtask

  task automatic chk_st();
    bus(1'b0, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_FLAGS, 8'h00);
    chk(rd & rtcam_pkg::FLAG_MASK, {2'b0, e_tf, 1'b0, e_af, e_cf, 2'b0}, "flags");
    bus(1'b0, rtcam_pkg::PAGE_IRQ, rtcam_pkg::IDX_IRQ_STAT, 8'h00);
    chk(rd & 8'h07, {5'h0, e_st}, "irq status");
    chk({7'h0, irq}, {7'h0, |(e_st & e_en)}, "irq line");
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    $display("BAD %0t run timeout", $time);
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, avs_address, avs_read, avs_write, avs_writedata} = '0;
    {cur_min, cur_hour, cur_day, cur_wday, time_update, tick_event, countdown_event} = '0;
    be_sel = 4'hF;
    avs_byteenable = 4'hF;
    al = '{8'h80, 8'h80, 8'h80, 8'h80};
    {pm, e_af, e_tf, e_cf, e_st, e_en} = '0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(32'h336F));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, rtcam_pkg::PAGE_RTC, ridx[i], 8'h00);
      chk(rd & rmsk[i], rexp[i], "reset value");
    end
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
        bus(1'b1, rtcam_pkg::PAGE_RTC, ridx[i], v);
        bus(1'b0, rtcam_pkg::PAGE_RTC, ridx[i], 8'h00);
        chk(rd & rmsk[i], v & rmsk[i], "readback");
      end
    end
    for (int i = 0; i < 4; i++) walarm(i, 8'h80);
    bus(1'b1, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_YEAR, 8'h99);
    be_sel = 4'hE;
    bus(1'b1, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_YEAR, 8'h42);
    be_sel = 4'hF;
    bus(1'b0, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_YEAR, 8'h00);
    chk(rd, 8'h99, "masked write");
    bus(1'b1, 2'h2, rtcam_pkg::IDX_MONTH, 8'h12);
    bus(1'b0, 2'h2, rtcam_pkg::IDX_MONTH, 8'h00);
    chk(rd, 8'h00, "unmapped");
    // Flag register keeps AND semantics on every write
    wirq(rtcam_pkg::IDX_IRQ_EN, 3'h7);
    evt(1'b1, 1'b1);
    chk_st();
    repeat (3) wflags(8'hF7);
    chk_st();
    wflags(8'hDF);
    chk_st();
    wflags(8'hFB);
    chk_st();
    wirq(rtcam_pkg::IDX_IRQ_CLR, 3'h6);
    walarm(0, 8'h30);
    upd(8'h29, 8'h10, 8'h05, 3'h2);
    chk_st();
    upd(8'h30, 8'h10, 8'h05, 3'h2);
    chk_st();
    upd(8'h31, 8'h10, 8'h05, 3'h2);
    chk_st();
    wflags(8'hF7);
    upd(8'h30, 8'h10, 8'h05, 3'h2);
    wflags(8'hF7);
    upd(8'h30, 8'h10, 8'h05, 3'h2);
    chk_st();
    wirq(rtcam_pkg::IDX_IRQ_EN, 3'h0);
    chk_st();
    wirq(rtcam_pkg::IDX_IRQ_CLR, 3'h1);
    wirq(rtcam_pkg::IDX_IRQ_EN, 3'h1);
    // All four fields armed, 12-hour mode with afternoon bit
    bus(1'b1, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_CTRL1, 8'h04);
    walarm(1, 8'h21);
    walarm(2, 8'h15);
    walarm(3, 8'h06);
    upd(8'h30, 8'h01, 8'h15, 3'h6);
    chk_st();
    upd(8'h30, 8'h21, 8'h15, 3'h5);
    chk_st();
    upd(8'h30, 8'h21, 8'h15, 3'h6);
    chk_st();
    walarm(1, 8'hA1);
    wflags(8'hF7);
    upd(8'h31, 8'h01, 8'h15, 3'h6);
    upd(8'h30, 8'h01, 8'h15, 3'h6);
    chk_st();
    bus(1'b1, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_CTRL1, 8'h00);
    // Random alarms and times, each field half the time on target
    for (int it = 0; it < 60; it++) begin
      if (it % 10 == 0) begin
        v = bcd($urandom % 60);
        walarm(0, {($urandom % 3 == 0), v[6:0]});
        v = bcd($urandom % 24);
        walarm(1, {($urandom % 3 == 0), 1'b0, v[5:0]});
        v = bcd(1 + $urandom % 31);
        walarm(2, {($urandom % 3 == 0), 1'b0, v[5:0]});
        walarm(3, {($urandom % 3 == 0), 4'h0, 3'($urandom % 7)});
      end
      cm = ($urandom % 2) ? {1'b0, al[0][6:0]} : bcd($urandom % 60);
      ch = ($urandom % 2) ? {2'b0, al[1][5:0]} : bcd($urandom % 24);
      cd = ($urandom % 2) ? {2'b0, al[2][5:0]} : bcd(1 + $urandom % 31);
      cw = ($urandom % 2) ? al[3][2:0] : 3'($urandom % 7);
      upd(cm, ch, cd, cw);
      chk_st();
      if ($urandom % 3 == 0) wflags(8'hF7);
      if ($urandom % 4 == 0) wirq(rtcam_pkg::IDX_IRQ_CLR, 3'h1);
    end
    cnt = 0;
    repeat (100) begin
      @(posedge ref_clk);
      if (time_tick === 1'b1) cnt++;
    end
    chk(8'(cnt), 8'h0A, "tick count");
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, rtcam_pkg::PAGE_RTC, rtcam_pkg::IDX_AMIN, 8'h00);
    chk(rd, 8'h80, "second reset");
    test_done();
  end
endmodule
